// file: core/tmc_cw_if.sv
`timescale 1ns/1ps
interface tmc_cw_if;
    logic cw_rd;
    logic cw_wr;
    logic [tmc_pkg::CW_W-1:0] cw_wdata;
    logic [tmc_pkg::CW_W-1:0] cw_rdata;
    logic [tmc_pkg::CW_W-1:0] cw_live;
    logic cw_ack;
    logic te_state;

    modport dev (
        input cw_rd,
        input cw_wr,
        input cw_wdata,
        output cw_rdata,
        output cw_live,
        output cw_ack,
        output te_state
    );

    modport host (
        output cw_rd,
        output cw_wr,
        output cw_wdata,
        input cw_rdata,
        input cw_live,
        input cw_ack,
        input te_state
    );
endinterface : tmc_cw_if

// file: core/tmc_dev.sv
// What this block does
// - Force-busy bit makes commands answer Busy
// - Busy: no mode data, pointer unchanged
// - Mode code 8 ignores force-busy
// - Set accessed flag at message completion
// - Accessed flag clears on resets, reads
// - Pointer-B bit picks buffer A or B
// - Invert pointer-B after clean ping-pong message
// - Keep pointer-B on error, illegal, Busy
// - Both resets clear pointer-B to zero
// - Flag valid broadcast transmit mode commands
// - Device asserts ping-pong acknowledge when active
// - Stop request answered by negating acknowledge
// - Stop cleared answered by asserting acknowledge
// - Enabled but unacknowledged: single buffer, no toggle
// - Enable bit selects ping-pong or indexed
// - Host cannot write bits 8 to 11
// - Enable bit changes only while not executing
`timescale 1ns/1ps
module tmc_dev (
    // Clock and master reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Host side of the control word
    tmc_cw_if.dev cw,
    // Terminal configuration
    input wire logic soft_reset_cmd,
    input wire logic terminal_execute,
    input wire logic broadcast_disable,
    // Command traffic for this mode code
    input wire logic cmd_valid,
    input wire logic [4:0] cmd_mode_code,
    input wire logic cmd_broadcast,
    input wire logic cmd_illegal,
    input wire logic msg_done,
    input wire logic msg_error,
    // Response steering
    output logic resp_busy,
    output logic send_mode_data,
    output logic use_pointer_b,
    output logic pingpong_in_use,
    output logic msg_active
);

    typedef struct packed {
        logic [tmc_pkg::CW_W-1:0] cw;
        logic [tmc_pkg::CW_W-1:0] rdata;
        logic ack;
        logic te;
        logic in_msg;
        logic busy;
        logic illegal;
        logic pp_used;
        logic resp_busy;
        logic send_data;
        logic use_b;
    } tmc_dev_st_t;

    localparam tmc_dev_st_t ST_RESET = '{
        cw: tmc_pkg::CW_RESET,
        rdata: tmc_pkg::CW_RESET,
        ack: 1'b0,
        te: 1'b0,
        in_msg: 1'b0,
        busy: 1'b0,
        illegal: 1'b0,
        pp_used: 1'b0,
        resp_busy: 1'b0,
        send_data: 1'b0,
        use_b: 1'b0
    };

    // One-hot views of the bits this block owns
    localparam logic [tmc_pkg::CW_W-1:0] ONE_BIT = 13'h0001;
    localparam logic [tmc_pkg::CW_W-1:0] SOFT_RESET_CMD_BITS = (ONE_BIT << tmc_pkg::BIT_ACCESSED)
        | (ONE_BIT << tmc_pkg::BIT_PTR_B)
        | (ONE_BIT << tmc_pkg::BIT_BROADCAST_SEEN_FLAG);
    localparam logic [tmc_pkg::CW_W-1:0] HOST_BITS = (ONE_BIT << tmc_pkg::BIT_FORCE_BUSY)
        | (ONE_BIT << tmc_pkg::BIT_PP_STOP)
        | (ONE_BIT << tmc_pkg::BIT_PP_EN);

    // Refuse a package whose geometry the logic cannot serve
    if (tmc_pkg::BIT_FORCE_BUSY >= tmc_pkg::CW_W) begin : g_bad_width
        $error("control word too narrow");
    end
    if (tmc_pkg::CW_SOFT_RESET_CMD_MASK != SOFT_RESET_CMD_BITS) begin : g_bad_soft_reset_cmd
        $error("soft reset mask disagrees with flag positions");
    end
    if ((HOST_BITS & ~tmc_pkg::CW_USED_MASK) != '0) begin : g_bad_used
        $error("host bit outside used mask");
    end
    if (tmc_pkg::MC_RESET_RT >= tmc_pkg::MC_FIRST_DATA) begin : g_bad_codes
        $error("reset code must carry no mode data");
    end
    if (tmc_pkg::CW_RESET != '0) begin : g_bad_reset
        $error("reset word must be all zero");
    end
    if (tmc_pkg::BIT_PP_EN == tmc_pkg::BIT_PP_STOP) begin : g_bad_stop
        $error("enable and stop bits must differ");
    end

    tmc_dev_st_t st_r;
    tmc_dev_st_t st_nxt;

    logic busy_now;
    logic pp_now;
    // Command link qualifiers
    logic take_cmd;
    logic take_done;
    logic clean_pp;

    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.te = terminal_execute;
        busy_now = st_r.cw[tmc_pkg::BIT_FORCE_BUSY]
            && (cmd_mode_code != tmc_pkg::MC_RESET_RT);
        pp_now = st_r.cw[tmc_pkg::BIT_PP_EN] && st_r.cw[tmc_pkg::BIT_PP_ACK];
        // Requests outside the legal order are dropped
        take_cmd = cmd_valid && !st_r.in_msg;
        take_done = msg_done && st_r.in_msg;
        // Only a clean ping-pong message may toggle the pointer
        clean_pp = st_r.pp_used && !msg_error && !st_r.busy && !st_r.illegal;

        // Host write: only host bits are taken
        if (cw.cw_wr) begin
            st_nxt.cw[tmc_pkg::BIT_FORCE_BUSY] = cw.cw_wdata[tmc_pkg::BIT_FORCE_BUSY];
            st_nxt.cw[tmc_pkg::BIT_PP_STOP] = cw.cw_wdata[tmc_pkg::BIT_PP_STOP];
            if (!terminal_execute) begin
                st_nxt.cw[tmc_pkg::BIT_PP_EN] = cw.cw_wdata[tmc_pkg::BIT_PP_EN];
            end
            st_nxt.ack = 1'b1;
        end

        // Host read returns the word as it stood, then clears accessed
        if (cw.cw_rd) begin
            st_nxt.rdata = st_r.cw;
            st_nxt.cw[tmc_pkg::BIT_ACCESSED] = 1'b0;
            st_nxt.ack = 1'b1;
        end

        // Command start
        if (take_cmd) begin
            st_nxt.in_msg = 1'b1;
            st_nxt.busy = busy_now;
            st_nxt.illegal = cmd_illegal;
            st_nxt.pp_used = pp_now;
            st_nxt.resp_busy = busy_now;
            st_nxt.send_data = !busy_now && !cmd_illegal
                && (cmd_mode_code >= tmc_pkg::MC_FIRST_DATA);
            // Pointer only matters when ping-pong is enabled
            st_nxt.use_b = st_r.cw[tmc_pkg::BIT_PP_EN]
                && st_r.cw[tmc_pkg::BIT_PTR_B];
            if (cmd_broadcast && !cmd_illegal && !broadcast_disable) begin
                st_nxt.cw[tmc_pkg::BIT_BROADCAST_SEEN_FLAG] = 1'b1;
            end
        end

        // Message completion; the set beats a same-cycle read clear
        if (take_done) begin
            st_nxt.in_msg = 1'b0;
            st_nxt.resp_busy = 1'b0;
            st_nxt.send_data = 1'b0;
            st_nxt.cw[tmc_pkg::BIT_ACCESSED] = 1'b1;
            if (clean_pp) begin
                st_nxt.cw[tmc_pkg::BIT_PTR_B] = !st_r.cw[tmc_pkg::BIT_PTR_B];
            end
        end

        // Acknowledge tracks enable and stop between messages while executing
        if (!st_r.in_msg && terminal_execute) begin
            st_nxt.cw[tmc_pkg::BIT_PP_ACK] = st_r.cw[tmc_pkg::BIT_PP_EN]
                && !st_r.cw[tmc_pkg::BIT_PP_STOP];
        end

        // Software reset clears the accessed, pointer-B and broadcast flags and ends any message
        if (soft_reset_cmd) begin
            st_nxt.cw = st_nxt.cw & ~tmc_pkg::CW_SOFT_RESET_CMD_MASK;
            st_nxt.in_msg = 1'b0;
            st_nxt.resp_busy = 1'b0;
            st_nxt.send_data = 1'b0;
        end

        st_nxt.cw = st_nxt.cw & tmc_pkg::CW_USED_MASK;
    end

    // Master reset clears the whole word
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Every output comes straight from the state register
    assign cw.cw_rdata = st_r.rdata;
    assign cw.cw_live = st_r.cw;
    assign cw.cw_ack = st_r.ack;
    assign cw.te_state = st_r.te;

    assign resp_busy = st_r.resp_busy;
    assign send_mode_data = st_r.send_data;
    assign use_pointer_b = st_r.use_b;
    assign pingpong_in_use = st_r.pp_used;
    assign msg_active = st_r.in_msg;

endmodule : tmc_dev

// file: core/tmc_host.sv
`timescale 1ns/1ps
module tmc_host (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Buffer servicing permit
    output logic buffer_service_ok,
    // Control word link
    tmc_cw_if.host cw
);

    typedef enum logic [1:0] {S_IDLE, S_WAIT_DEV, S_DONE} tmc_hst_state_t;

    typedef struct packed {
        tmc_hst_state_t state;
        logic waitreq;
        logic [31:0] rdata;
        logic rd;
        logic wr;
        logic [tmc_pkg::CW_W-1:0] wdata;
        logic svc_ok;
    } tmc_hst_st_t;

    tmc_hst_st_t st_r;
    tmc_hst_st_t st_nxt;

    logic [tmc_pkg::CW_W-1:0] merged;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rd = 1'b0;
        st_nxt.wr = 1'b0;
        // Buffer may be loaded only while stop is held and ack is low
        st_nxt.svc_ok = cw.cw_live[tmc_pkg::BIT_PP_STOP]
            && !cw.cw_live[tmc_pkg::BIT_PP_ACK];
        merged = cw.cw_live;
        if (avs_byteenable[0]) begin
            merged[tmc_pkg::BIT_PP_STOP] = avs_writedata[tmc_pkg::BIT_PP_STOP];
            if (!cw.te_state) begin
                merged[tmc_pkg::BIT_PP_EN] = avs_writedata[tmc_pkg::BIT_PP_EN];
            end
        end
        if (avs_byteenable[1]) begin
            merged[tmc_pkg::BIT_FORCE_BUSY] = avs_writedata[tmc_pkg::BIT_FORCE_BUSY];
        end
        unique case (st_r.state)
            S_IDLE: begin
                if (avs_read || avs_write) begin
                    if (avs_address == tmc_pkg::OFS_CW) begin
                        st_nxt.rd = avs_read;
                        st_nxt.wr = avs_write;
                        st_nxt.wdata = merged;
                        st_nxt.state = S_WAIT_DEV;
                    end else if (avs_write && avs_address == tmc_pkg::OFS_SERVICE
                        && avs_byteenable[0]) begin
                        st_nxt.wr = 1'b1;
                        st_nxt.wdata = cw.cw_live;
                        st_nxt.wdata[tmc_pkg::BIT_PP_STOP] = avs_writedata[0];
                        st_nxt.state = S_WAIT_DEV;
                    end else begin
                        st_nxt.rdata = 32'h0000_0000;
                        if (avs_read && avs_address == tmc_pkg::OFS_SERVICE) begin
                            st_nxt.rdata[0] = cw.cw_live[tmc_pkg::BIT_PP_STOP];
                        end else if (avs_read && avs_address == tmc_pkg::OFS_STATUS) begin
                            st_nxt.rdata[tmc_pkg::ST_STOP] = cw.cw_live[tmc_pkg::BIT_PP_STOP];
                            st_nxt.rdata[tmc_pkg::ST_ACK] = cw.cw_live[tmc_pkg::BIT_PP_ACK];
                            st_nxt.rdata[tmc_pkg::ST_SVC_OK] = st_r.svc_ok;
                            st_nxt.rdata[tmc_pkg::ST_TE] = cw.te_state;
                        end
                        st_nxt.waitreq = 1'b0;
                        st_nxt.state = S_DONE;
                    end
                end
            end
            S_WAIT_DEV: begin
                if (cw.cw_ack) begin
                    st_nxt.rdata = {19'h0, cw.cw_rdata};
                    st_nxt.waitreq = 1'b0;
                    st_nxt.state = S_DONE;
                end
            end
            S_DONE: begin
                st_nxt.waitreq = 1'b1;
                st_nxt.state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '{state: S_IDLE, waitreq: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = st_r.waitreq;
    assign buffer_service_ok = st_r.svc_ok;
    assign cw.cw_rd = st_r.rd;
    assign cw.cw_wr = st_r.wr;
    assign cw.cw_wdata = st_r.wdata;

endmodule : tmc_host

// file: core/tmc_pkg.sv
package tmc_pkg;
    // Control word geometry (bits 12..0 handled here)
    localparam int unsigned CW_W = 13;
    localparam int unsigned BIT_FORCE_BUSY = 12;
    localparam int unsigned BIT_ACCESSED = 11;
    localparam int unsigned BIT_PTR_B = 10;
    localparam int unsigned BIT_BROADCAST_SEEN_FLAG = 9;
    localparam int unsigned BIT_PP_ACK = 8;
    localparam int unsigned BIT_PP_STOP = 3;
    localparam int unsigned BIT_PP_EN = 2;
    localparam logic [CW_W-1:0] CW_RESET = 13'h0000;
    localparam logic [CW_W-1:0] CW_USED_MASK = 13'h1f0c;
    localparam logic [CW_W-1:0] CW_SOFT_RESET_CMD_MASK = 13'h0e00;

    // Mode codes
    localparam logic [4:0] MC_RESET_RT = 5'h08;
    localparam logic [4:0] MC_FIRST_DATA = 5'h10;

    // Avalon byte offsets of the controller registers
    localparam logic [3:0] OFS_CW = 4'h0;
    localparam logic [3:0] OFS_SERVICE = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    // STATUS register fields
    localparam int unsigned ST_STOP = 0;
    localparam int unsigned ST_ACK = 1;
    localparam int unsigned ST_SVC_OK = 2;
    localparam int unsigned ST_TE = 3;
endpackage : tmc_pkg

// file: tb/tmc_cw_props.sv
`timescale 1ns/1ps
module tmc_cw_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Control word link
    input wire logic cw_rd,
    input wire logic cw_wr,
    input wire logic [tmc_pkg::CW_W-1:0] cw_wdata,
    input wire logic [tmc_pkg::CW_W-1:0] cw_rdata,
    input wire logic [tmc_pkg::CW_W-1:0] cw_live,
    input wire logic cw_ack,
    input wire logic te_state
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence rd_ack_s;
        cw_rd ##1 cw_ack;
    endsequence
    sequence wr_ack_s;
        cw_wr && !cw_rd ##1 cw_ack;
    endsequence
    ack_follow_a: assert property ((cw_rd || cw_wr) |=> cw_ack) else $error("no link ack");
    ack_cause_a: assert property (cw_ack |-> $past(cw_rd || cw_wr)) else $error("stray ack");
    rd_snap_a: assert property (rd_ack_s |-> cw_rdata == $past(cw_live))
        else $error("read word wrong");
    wr_bits_a: assert property (wr_ack_s |-> cw_live[12] == $past(cw_wdata[12])
        && cw_live[3] == $past(cw_wdata[3])) else $error("host bits not written");
    unused_zero_a: assert property ((cw_live & ~tmc_pkg::CW_USED_MASK) == '0)
        else $error("unused bit set");
    en_lock_a: assert property ($changed(cw_live[2]) |-> !$past(te_state))
        else $error("enable moved while executing");
    ack_rise_a: assert property ($rose(cw_live[8])
        |-> $past(cw_live[2]) && !$past(cw_live[3])) else $error("ack rose wrongly");
    ack_fall_a: assert property ($fell(cw_live[8])
        |-> $past(cw_live[3]) || !$past(cw_live[2])) else $error("ack fell wrongly");
    ack_hold_a: assert property ($changed(cw_live[8]) |-> te_state)
        else $error("ack moved while stopped");
    ptr_toggle_a: assert property ($rose(cw_live[10])
        |-> cw_live[11] && $past(cw_live[8])) else $error("pointer rose wrongly");
endmodule : tmc_cw_props

// file: tb/tx_mode_cmd_control_word_bench.sv
`timescale 1ns/1ps
module tx_mode_cmd_control_word_bench;
    logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest, svc_ok;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic soft_reset_cmd, terminal_execute, broadcast_disable, cmd_valid, cmd_broadcast;
    logic cmd_illegal, msg_done, msg_error, resp_busy, send_mode_data, use_pointer_b;
    logic pingpong_in_use, msg_active;
    logic [4:0] cmd_mode_code;
    int fail_count, check_count;
    tmc_cw_if cw_bus();
    tmc_host u_tmc_host (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .buffer_service_ok(svc_ok), .cw(cw_bus.host));
    tmc_dev u_tmc_dev (.sys_clk(sys_clk), .reset_n(reset_n), .cw(cw_bus.dev),
        .soft_reset_cmd(soft_reset_cmd), .terminal_execute(terminal_execute),
        .broadcast_disable(broadcast_disable), .cmd_valid(cmd_valid),
        .cmd_mode_code(cmd_mode_code), .cmd_broadcast(cmd_broadcast), .cmd_illegal(cmd_illegal),
        .msg_done(msg_done), .msg_error(msg_error), .resp_busy(resp_busy),
        .send_mode_data(send_mode_data), .use_pointer_b(use_pointer_b),
        .pingpong_in_use(pingpong_in_use), .msg_active(msg_active));
    tmc_cw_props props (.sys_clk(sys_clk), .reset_n(reset_n), .cw_rd(cw_bus.cw_rd),
        .cw_wr(cw_bus.cw_wr), .cw_wdata(cw_bus.cw_wdata), .cw_rdata(cw_bus.cw_rdata),
        .cw_live(cw_bus.cw_live), .cw_ack(cw_bus.cw_ack), .te_state(cw_bus.te_state));
    task close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task av(input logic w, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            close_out();
        end
    endtask : av
    task rdc(input logic [3:0] a, input logic [12:0] exp);
        av(1'b0, a, 32'h0000_0000);
        chk("reg", {19'h0, exp}, rd);
    endtask : rdc
    task cmd(input logic [4:0] mc, input logic bc, il, er, input logic [3:0] exp);
        cmd_mode_code <= mc;
        cmd_broadcast <= bc;
        cmd_illegal <= il;
        cmd_valid <= 1'b1;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        @(negedge sys_clk);
        chk("steer", {27'h0, 1'b1, exp}, {27'h0, msg_active, resp_busy, send_mode_data,
            use_pointer_b, pingpong_in_use});
        @(posedge sys_clk);
        msg_done <= 1'b1;
        msg_error <= er;
        @(posedge sys_clk);
        msg_done <= 1'b0;
        @(posedge sys_clk);
    endtask : cmd
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        {reset_n, avs_read, avs_write, soft_reset_cmd, terminal_execute} = '0;
        {broadcast_disable, cmd_valid, cmd_broadcast, cmd_illegal, msg_done, msg_error} = '0;
        {avs_address, avs_writedata, cmd_mode_code, fail_count, check_count} = '0;
        avs_byteenable = 4'hf;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        rdc(4'h0, 13'h0000);
        av(1'b1, 4'h0, 32'h0000_1fff);
        rdc(4'h0, 13'h100c);
        av(1'b1, 4'h0, 32'h0000_0004);
        terminal_execute <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rdc(4'h0, 13'h0104);
        cmd(5'h10, 1'b0, 1'b0, 1'b0, 4'h5);
        rdc(4'h0, 13'h0d04);
        rdc(4'h0, 13'h0504);
        cmd(5'h10, 1'b0, 1'b0, 1'b1, 4'h7);
        rdc(4'h0, 13'h0d04);
        cmd(5'h10, 1'b0, 1'b1, 1'b0, 4'h3);
        rdc(4'h0, 13'h0d04);
        av(1'b1, 4'h0, 32'h0000_1004);
        cmd(5'h14, 1'b0, 1'b0, 1'b0, 4'hb);
        rdc(4'h0, 13'h1d04);
        cmd(5'h08, 1'b1, 1'b0, 1'b0, 4'h3);
        rdc(4'h0, 13'h1b04);
        av(1'b1, 4'h0, 32'h0000_000c);
        repeat (2) @(posedge sys_clk);
        rdc(4'h8, 13'h000d);
        chk("svc_ok", 32'h0000_0001, {31'h0, svc_ok});
        rdc(4'h0, 13'h020c);
        cmd(5'h10, 1'b0, 1'b0, 1'b0, 4'h4);
        rdc(4'h0, 13'h0a0c);
        av(1'b1, 4'h4, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        rdc(4'h0, 13'h0304);
        chk("svc_ok", 32'h0000_0000, {31'h0, svc_ok});
        av(1'b1, 4'h0, 32'h0000_0000);
        rdc(4'h0, 13'h0304);
        soft_reset_cmd <= 1'b1;
        @(posedge sys_clk);
        soft_reset_cmd <= 1'b0;
        rdc(4'h0, 13'h0104);
        rdc(4'hc, 13'h0000);
        close_out();
    end
endmodule : tx_mode_cmd_control_word_bench
